// ==== smtc_pkg.sv ====
package smtc_pkg;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [2:0] CMD_APPLY_HELD = 3'h0;
  localparam logic [2:0] CMD_ENABLE_COND = 3'h1;
  localparam logic [2:0] CMD_DISABLE_COND = 3'h2;
  localparam logic [2:0] CMD_QUERY_MASK = 3'h3;
  localparam logic [2:0] CMD_CAL_LOW = 3'h4;
  localparam logic [2:0] CMD_CAL_HIGH = 3'h5;
  localparam logic [2:0] CMD_CAL_COMPUTE = 3'h6;

  // ==========================================================================
  // Condition names carried by list tokens
  // ==========================================================================
  localparam logic [2:0] NAME_CONST_VOLT = 3'h0;
  localparam logic [2:0] NAME_CONST_CURR = 3'h1;
  localparam logic [2:0] NAME_OVERVOLT = 3'h2;
  localparam logic [2:0] NAME_SHUTDOWN = 3'h3;
  localparam logic [2:0] NAME_FOLDBACK = 3'h4;
  localparam logic [2:0] NAME_ERR = 3'h5;
  localparam logic [2:0] NAME_ALL = 3'h6;
  localparam logic [2:0] NAME_NONE = 3'h7;

  // ==========================================================================
  // Condition bit positions
  // ==========================================================================
  localparam int BIT_CONST_VOLT = 0;
  localparam int BIT_CONST_CURR = 1;
  localparam int BIT_OVERVOLT = 3;
  localparam int BIT_SHUTDOWN = 5;
  localparam int BIT_FOLDBACK = 6;
  localparam int BIT_ERR = 7;
  localparam int COND_W = 8;
  localparam logic [7:0] COND_ALL = 8'hEB;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // ==========================================================================
  // Calibration points, as DAC codes
  // ==========================================================================
  localparam logic [15:0] CAL_LOW_CODE = 16'h0CCC;
  localparam logic [15:0] CAL_HIGH_CODE = 16'hF333;
  localparam logic [15:0] CAL_SPAN = 16'hE667;

endpackage

// ==== smtc_list_if.sv ====
`timescale 1ns/1ps
interface smtc_list_if;
  import smtc_pkg::*;
  logic start;
  logic token_valid;
  logic token_is_number;
  logic [2:0] token_name;
  logic [7:0] token_number;
  logic token_last;
  logic done;
  logic [7:0] bits;
  logic none_seen;
  logic error;

  modport ctrl (
    output start,
    output token_valid,
    output token_is_number,
    output token_name,
    output token_number,
    output token_last,
    input done,
    input bits,
    input none_seen,
    input error
  );

  modport accum (
    input start,
    input token_valid,
    input token_is_number,
    input token_name,
    input token_number,
    input token_last,
    output done,
    output bits,
    output none_seen,
    output error
  );
endinterface

// ==== smtc_cond_accum.sv ====
`timescale 1ns/1ps
module smtc_cond_accum
  import smtc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  smtc_list_if.accum lst
);

  logic [7:0] bits_reg;
  logic [7:0] bits_next;
  logic none_reg;
  logic none_next;
  logic err_reg;
  logic err_next;
  logic done_reg;
  logic done_next;
  logic [7:0] tok_bits;

  // ==========================================================================
  // Token decode and accumulation
  // ==========================================================================
  always_comb
  begin
    tok_bits = 8'h00;
    bits_next = bits_reg;
    none_next = none_reg;
    err_next = err_reg;
    done_next = 1'b0;
    if (lst.start)
    begin
      bits_next = 8'h00;
      none_next = 1'b0;
      err_next = 1'b0;
    end
    else if (lst.token_valid)
    begin
      if (lst.token_is_number)
      begin
        tok_bits = lst.token_number & COND_ALL;
        if ((lst.token_number & ~COND_ALL) != 8'h00)
        begin
          err_next = 1'b1;
        end
      end
      else
      begin
        case (lst.token_name)
          NAME_CONST_VOLT: tok_bits[BIT_CONST_VOLT] = 1'b1;
          NAME_CONST_CURR: tok_bits[BIT_CONST_CURR] = 1'b1;
          NAME_OVERVOLT: tok_bits[BIT_OVERVOLT] = 1'b1;
          NAME_SHUTDOWN: tok_bits[BIT_SHUTDOWN] = 1'b1;
          NAME_FOLDBACK: tok_bits[BIT_FOLDBACK] = 1'b1;
          NAME_ERR: tok_bits[BIT_ERR] = 1'b1;
          NAME_ALL: tok_bits = COND_ALL;
          NAME_NONE: none_next = 1'b1;
          default: err_next = 1'b1;
        endcase
      end
      // Names are merged by OR, so their order never matters.
      bits_next = bits_reg | tok_bits;
      done_next = lst.token_last;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bits_reg <= 8'h00;
      none_reg <= 1'b0;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      bits_reg <= bits_next;
      none_reg <= none_next;
      err_reg <= err_next;
      done_reg <= done_next;
    end
  end

  assign lst.done = done_reg;
  assign lst.bits = bits_reg;
  assign lst.none_seen = none_reg;
  assign lst.error = err_reg;

endmodule

// ==== smtc_cmd_top.sv ====
// Overview of operation
// - Apply-held command moves pending voltage and current into the active settings.
// - Held setpoints do not affect the output until the apply-held command.
// - Condition names arrive comma separated in any order; order is irrelevant.
// - A single decimal number may replace names; it is the sum of bit weights.
// - Only enabled conditions can set status and fault bits.
// - A fault bit sets when its status bit rises while its mask bit is one.
// - Six condition names plus ALL and NONE are recognised.
// - After reset no condition is enabled.
// - Mask query replies with the sum of weights of enabled conditions.
// - Compute command takes low and high measurements and stores slope and offset.
// - High-point command drives a fixed voltage near the top of the range.
// - Low-point command drives a fixed voltage near the bottom of the range.
// - Bit positions: voltage 0, current 1, overvoltage 3, shutdown 5, foldback 6, error 7.
// - Disable-conditions command removes the named conditions from the mask; with NONE it enables all conditions.
// - A status bit sets the cycle after its condition is true and enabled, and clears the cycle after either stops.
`timescale 1ns/1ps
module smtc_cmd_top
  import smtc_pkg::*;
#(
  parameter int SET_W = 16
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic token_valid,
  input wire logic token_is_number,
  input wire logic [2:0] token_name,
  input wire logic [7:0] token_number,
  input wire logic token_last,
  input wire logic [15:0] cal_vlo,
  input wire logic [15:0] cal_vhi,
  input wire logic hold_mode,
  input wire logic volt_set_valid,
  input wire logic [SET_W-1:0] volt_set_value,
  input wire logic curr_set_valid,
  input wire logic [SET_W-1:0] curr_set_value,
  input wire logic calibration_mode,
  input wire logic [7:0] condition_in,
  input wire logic [7:0] fault_clear,
  output logic busy,
  output logic cmd_error,
  output logic reply_valid,
  output logic [7:0] reply_mask,
  output logic [7:0] mask_bits,
  output logic [7:0] status_bits,
  output logic [7:0] fault_bits,
  output logic [SET_W-1:0] active_voltage,
  output logic [SET_W-1:0] active_current,
  output logic [15:0] prog_voltage,
  output logic cal_drive,
  output logic [15:0] cal_slope,
  output logic [15:0] cal_offset
);

  typedef enum logic [1:0] {ST_IDLE, ST_LIST, ST_APPLY} smtc_state_e;

  smtc_list_if lst ();

  smtc_cond_accum u_accum (
    .clk(clk),
    .sys_rst(sys_rst),
    .lst(lst)
  );

  smtc_state_e state_reg;
  smtc_state_e state_next;
  logic busy_reg;
  logic busy_next;
  logic disable_reg;
  logic disable_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] fault_reg;
  logic [7:0] fault_next;
  logic err_reg;
  logic err_next;
  logic reply_reg;
  logic reply_next;
  logic [7:0] reply_mask_reg;
  logic [7:0] reply_mask_next;
  logic [SET_W-1:0] pend_v_reg;
  logic [SET_W-1:0] pend_v_next;
  logic [SET_W-1:0] pend_i_reg;
  logic [SET_W-1:0] pend_i_next;
  logic [SET_W-1:0] act_v_reg;
  logic [SET_W-1:0] act_v_next;
  logic [SET_W-1:0] act_i_reg;
  logic [SET_W-1:0] act_i_next;
  logic cal_drive_reg;
  logic cal_drive_next;
  logic [15:0] cal_code_reg;
  logic [15:0] cal_code_next;
  logic [15:0] prog_reg;
  logic [15:0] prog_next;
  logic [15:0] slope_reg;
  logic [15:0] slope_next;
  logic [15:0] offset_reg;
  logic [15:0] offset_next;
  logic take_cmd;

  assign take_cmd = cmd_valid && (state_reg == ST_IDLE);
  assign lst.start = take_cmd;
  assign lst.token_valid = token_valid && (state_reg == ST_LIST);
  assign lst.token_is_number = token_is_number;
  assign lst.token_name = token_name;
  assign lst.token_number = token_number;
  assign lst.token_last = token_last;

  // ==========================================================================
  // Command sequencing and condition mask
  // ==========================================================================
  always_comb
  begin
    state_next = state_reg;
    disable_next = disable_reg;
    mask_next = mask_reg;
    err_next = 1'b0;
    reply_next = 1'b0;
    reply_mask_next = reply_mask_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (take_cmd)
        begin
          if (cmd_code == CMD_ENABLE_COND || cmd_code == CMD_DISABLE_COND)
          begin
            state_next = ST_LIST;
            disable_next = (cmd_code == CMD_DISABLE_COND);
          end
          else if (cmd_code == CMD_QUERY_MASK)
          begin
            reply_next = 1'b1;
            reply_mask_next = mask_reg;
          end
          else if (cmd_code > CMD_CAL_COMPUTE)
          begin
            err_next = 1'b1;
          end
          else if (cmd_code >= CMD_CAL_LOW && !calibration_mode)
          begin
            // Calibration without calibration mode is refused outright.
            err_next = 1'b1;
          end
        end
      end
      ST_LIST:
      begin
        if (token_valid && token_last)
        begin
          state_next = ST_APPLY;
        end
      end
      ST_APPLY:
      begin
        state_next = ST_IDLE;
        if (lst.error)
        begin
          err_next = 1'b1;
        end
        else if (!disable_reg)
        begin
          // NONE empties the selection; otherwise names add to it.
          mask_next = lst.none_seen ? 8'h00 : (mask_reg | lst.bits);
        end
        else
        begin
          mask_next = lst.none_seen ? COND_ALL : (mask_reg & ~lst.bits);
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    busy_next = (state_next != ST_IDLE);
  end

  // ==========================================================================
  // Status and fault capture
  // ==========================================================================
  always_comb
  begin
    // Status follows the condition level, gated by the mask.
    status_next = condition_in & mask_reg & COND_ALL;
    // A set in the same cycle as its clear wins over the clear.
    fault_next = (fault_reg & ~fault_clear) | (status_next & ~status_reg & mask_reg);
  end

  // ==========================================================================
  // Setpoints and calibration
  // ==========================================================================
  always_comb
  begin
    pend_v_next = (volt_set_valid && hold_mode) ? volt_set_value : pend_v_reg;
    pend_i_next = (curr_set_valid && hold_mode) ? curr_set_value : pend_i_reg;
    act_v_next = (volt_set_valid && !hold_mode) ? volt_set_value : act_v_reg;
    act_i_next = (curr_set_valid && !hold_mode) ? curr_set_value : act_i_reg;
    cal_drive_next = cal_drive_reg && calibration_mode;
    cal_code_next = cal_code_reg;
    slope_next = slope_reg;
    offset_next = offset_reg;
    if (take_cmd && cmd_code == CMD_APPLY_HELD)
    begin
      act_v_next = pend_v_reg;
      act_i_next = pend_i_reg;
    end
    if (take_cmd && calibration_mode)
    begin
      if (cmd_code == CMD_CAL_LOW)
      begin
        cal_drive_next = 1'b1;
        cal_code_next = CAL_LOW_CODE;
      end
      else if (cmd_code == CMD_CAL_HIGH)
      begin
        cal_drive_next = 1'b1;
        cal_code_next = CAL_HIGH_CODE;
      end
      else if (cmd_code == CMD_CAL_COMPUTE)
      begin
        // Gain is kept as the measured span over the fixed code span, which
        // avoids a divider; the consumer scales by CAL_SPAN.
        cal_drive_next = 1'b0;
        slope_next = cal_vhi - cal_vlo;
        offset_next = cal_vlo;
      end
    end
    prog_next = cal_drive_next ? cal_code_next : 16'(act_v_next);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      disable_reg <= 1'b0;
      mask_reg <= MASK_RESET;
      status_reg <= 8'h00;
      fault_reg <= 8'h00;
      err_reg <= 1'b0;
      reply_reg <= 1'b0;
      reply_mask_reg <= 8'h00;
      pend_v_reg <= '0;
      pend_i_reg <= '0;
      act_v_reg <= '0;
      act_i_reg <= '0;
      cal_drive_reg <= 1'b0;
      cal_code_reg <= 16'h0000;
      prog_reg <= 16'h0000;
      slope_reg <= 16'h0000;
      offset_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      disable_reg <= disable_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      fault_reg <= fault_next;
      err_reg <= err_next;
      reply_reg <= reply_next;
      reply_mask_reg <= reply_mask_next;
      pend_v_reg <= pend_v_next;
      pend_i_reg <= pend_i_next;
      act_v_reg <= act_v_next;
      act_i_reg <= act_i_next;
      cal_drive_reg <= cal_drive_next;
      cal_code_reg <= cal_code_next;
      prog_reg <= prog_next;
      slope_reg <= slope_next;
      offset_reg <= offset_next;
    end
  end

  assign busy = busy_reg;
  assign cmd_error = err_reg;
  assign reply_valid = reply_reg;
  assign reply_mask = reply_mask_reg;
  assign mask_bits = mask_reg;
  assign status_bits = status_reg;
  assign fault_bits = fault_reg;
  assign active_voltage = act_v_reg;
  assign active_current = act_i_reg;
  assign prog_voltage = prog_reg;
  assign cal_drive = cal_drive_reg;
  assign cal_slope = slope_reg;
  assign cal_offset = offset_reg;

endmodule

// ==== smtc_cmd_top_chk.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the command block
module smtc_cmd_top_chk
  import smtc_pkg::*;
#(
  parameter int SET_W = 16
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic busy,
  input wire logic cmd_error,
  input wire logic hold_mode,
  input wire logic calibration_mode,
  input wire logic [15:0] cal_vlo,
  input wire logic [15:0] cal_vhi,
  input wire logic [7:0] condition_in,
  input wire logic reply_valid,
  input wire logic [7:0] reply_mask,
  input wire logic [7:0] mask_bits,
  input wire logic [7:0] status_bits,
  input wire logic [7:0] fault_bits,
  input wire logic [SET_W-1:0] active_voltage,
  input wire logic [SET_W-1:0] active_current,
  input wire logic [15:0] prog_voltage,
  input wire logic cal_drive,
  input wire logic [15:0] cal_slope,
  input wire logic [15:0] cal_offset
);
  logic take;
  logic [7:0] prev_status_reg;
  logic [7:0] rise;
  logic [7:0] gated;
  logic [15:0] span;

  assign take = cmd_valid && !busy;
  assign gated = condition_in & mask_bits;
  assign span = cal_vhi - cal_vlo;
  // A rise is judged against the mask in force on the same edge.
  assign rise = status_bits & ~prev_status_reg & mask_bits;

  always_ff @(posedge clk)
  begin
    prev_status_reg <= status_bits;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_query_reply: assert property (take && cmd_code == CMD_QUERY_MASK |=>
    reply_valid && reply_mask == $past(mask_bits)) else $error("mask reply wrong");
  a_hold_keeps: assert property (hold_mode && !(take && cmd_code == CMD_APPLY_HELD) |=>
    $stable(active_voltage) && $stable(active_current)) else $error("held value leaked");
  a_status_follow: assert property (1'b1 |=>
    status_bits == $past(gated)) else $error("status mismatch");
  // The fault bit is captured on the same edge that raises the status bit.
  a_fault_rise: assert property (|rise |->
    (fault_bits & rise) == rise) else $error("fault not set");
  a_fault_gated: assert property (1'b1 |=>
    (fault_bits & ~$past(fault_bits) & ~$past(mask_bits)) == 8'h00) else $error("masked fault");
  a_cal_low: assert property (take && calibration_mode && cmd_code == CMD_CAL_LOW |=>
    cal_drive && prog_voltage == CAL_LOW_CODE) else $error("low point wrong");
  a_cal_high: assert property (take && calibration_mode && cmd_code == CMD_CAL_HIGH |=>
    cal_drive && prog_voltage == CAL_HIGH_CODE) else $error("high point wrong");
  a_cal_compute: assert property (take && calibration_mode && cmd_code == CMD_CAL_COMPUTE |=>
    cal_slope == $past(span) && cal_offset == $past(cal_vlo) && !cal_drive)
    else $error("compute wrong");
  a_cal_refused: assert property (take && !calibration_mode && cmd_code >= CMD_CAL_LOW &&
    cmd_code <= CMD_CAL_COMPUTE |=> cmd_error && !cal_drive) else $error("cal not refused");
endmodule

bind smtc_cmd_top smtc_cmd_top_chk #(.SET_W(SET_W)) i_smtc_cmd_top_chk (.*);

// ==== smtc_host_model.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Host side: issues commands and condition lists on the falling edge
module smtc_host_model
  import smtc_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] prog_voltage,
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic token_valid,
  output logic token_is_number,
  output logic [2:0] token_name,
  output logic [7:0] token_number,
  output logic token_last,
  output logic [15:0] cal_vlo,
  output logic [15:0] cal_vhi,
  output logic calibration_mode
);
  logic [15:0] m_lo;
  logic [15:0] m_hi;

  initial
  begin
    {cmd_valid, cmd_code, token_valid, token_is_number, token_name} = 8'h00;
    {token_number, token_last, calibration_mode} = 10'h000;
    {cal_vlo, cal_vhi} = 32'h0000_0000;
  end

  // Returns one and a half cycles after the taking edge, so any held answer is visible.
  task automatic send(input logic [2:0] c);
    cmd_valid = 1'b1;
    cmd_code = c;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~c;
    @(negedge clk);
  endtask

  // Token k takes its name from nm[3k+2:3k].
  task automatic lst(input logic [2:0] c, input int n, input logic [11:0] nm,
                     input logic isn, input logic [7:0] num);
    send(c);
    for (int i = 0; i < n; i++)
    begin
      token_valid = 1'b1;
      token_is_number = isn;
      token_name = nm[3*i +: 3];
      token_number = num;
      token_last = (i == n - 1);
      @(negedge clk);
    end
    token_valid = 1'b0;
    token_last = 1'b0;
    token_number = ~num;
    repeat (2) @(negedge clk);
  endtask

  task automatic cal_run();
    calibration_mode = 1'b1;
    @(negedge clk);
    send(CMD_CAL_LOW);
    m_lo = prog_voltage;
    send(CMD_CAL_HIGH);
    m_hi = prog_voltage;
    cal_vlo = m_lo;
    cal_vhi = m_hi;
    send(CMD_CAL_COMPUTE);
  endtask
endmodule

// ==== smtc_cmd_top_tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Testbench
module smtc_cmd_top_tb_top;
  import smtc_pkg::*;
  logic clk, sys_rst, hold_mode, volt_set_valid, curr_set_valid, cmd_valid;
  logic token_valid, token_is_number, token_last, calibration_mode;
  logic busy, cmd_error, reply_valid, cal_drive;
  logic [2:0] cmd_code, token_name;
  logic [7:0] token_number, condition_in, fault_clear, reply_mask;
  logic [7:0] mask_bits, status_bits, fault_bits;
  logic [15:0] cal_vlo, cal_vhi, volt_set_value, curr_set_value, active_voltage;
  logic [15:0] active_current, prog_voltage, cal_slope, cal_offset;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int reply_cnt = 0;
  int err_cnt = 0;

  smtc_cmd_top i_smtc_cmd_top (.*);
  smtc_host_model i_smtc_host_model (.*);

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic ml(input logic [2:0] c, input int n, input logic [11:0] nm,
                    input logic isn, input logic [7:0] num, input logic [7:0] e);
    i_smtc_host_model.lst(c, n, nm, isn, num);
    chk("mask_bits", mask_bits, e);
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang is cut off well past the roughly 70 cycles the tests need.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    // One-cycle pulses are counted here so no check can miss them.
    if (reply_valid)
      reply_cnt <= reply_cnt + 1;
    if (cmd_error)
      err_cnt <= err_cnt + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      stop_test();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    {hold_mode, volt_set_valid, curr_set_valid} = 3'h0;
    {volt_set_value, curr_set_value} = 32'h0000_0000;
    {condition_in, fault_clear} = 16'h0000;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    chk("mask_bits", mask_bits, 8'h00);
    i_smtc_host_model.send(CMD_QUERY_MASK);
    chk("reply_valid", 16'(reply_cnt), 16'h0001);
    chk("reply_mask", reply_mask, 8'h00);
    ml(CMD_ENABLE_COND, 3, {3'h0, NAME_ERR, NAME_FOLDBACK, NAME_CONST_CURR}, 1'b0, 8'h00,
       8'hC2);
    ml(CMD_ENABLE_COND, 1, 12'h000, 1'b1, 8'h29, 8'hEB);
    ml(CMD_DISABLE_COND, 1, {9'h000, NAME_SHUTDOWN}, 1'b0, 8'h00, 8'hCB);
    i_smtc_host_model.send(CMD_QUERY_MASK);
    chk("reply_mask", reply_mask, 8'hCB);
    chk("reply_valid", 16'(reply_cnt), 16'h0002);
    ml(CMD_DISABLE_COND, 1, {9'h000, NAME_NONE}, 1'b0, 8'h00, 8'hEB);
    ml(CMD_ENABLE_COND, 1, {9'h000, NAME_ALL}, 1'b0, 8'h00, 8'hEB);
    ml(CMD_ENABLE_COND, 1, {9'h000, NAME_NONE}, 1'b0, 8'h00, 8'h00);
    ml(CMD_ENABLE_COND, 2, {6'h00, NAME_CONST_VOLT, NAME_OVERVOLT}, 1'b0, 8'h00, 8'h09);
    ml(CMD_ENABLE_COND, 1, 12'h000, 1'b1, 8'h14, 8'h09);
    chk("cmd_error", 16'(err_cnt), 16'h0001);
    condition_in = 8'hFF;
    repeat (2) @(negedge clk);
    chk("status_bits", status_bits, 8'h09);
    chk("fault_bits", fault_bits, 8'h09);
    fault_clear = 8'hFF;
    @(negedge clk);
    fault_clear = 8'h00;
    @(negedge clk);
    chk("status_bits", status_bits, 8'h09);
    chk("fault_bits", fault_bits, 8'h00);
    condition_in = 8'h00;
    repeat (2) @(negedge clk);
    chk("status_bits", status_bits, 8'h00);
    chk("fault_bits", fault_bits, 8'h00);
    hold_mode = 1'b1;
    {volt_set_valid, curr_set_valid} = 2'h3;
    volt_set_value = 16'h1234;
    curr_set_value = 16'h0567;
    @(negedge clk);
    {volt_set_valid, curr_set_valid} = 2'h0;
    @(negedge clk);
    chk("active_voltage", active_voltage, 16'h0000);
    chk("prog_voltage", prog_voltage, 16'h0000);
    i_smtc_host_model.send(CMD_APPLY_HELD);
    chk("active_voltage", active_voltage, 16'h1234);
    chk("active_current", active_current, 16'h0567);
    chk("prog_voltage", prog_voltage, 16'h1234);
    i_smtc_host_model.send(CMD_CAL_HIGH);
    chk("cmd_error", 16'(err_cnt), 16'h0002);
    chk("cal_drive", cal_drive, 1'b0);
    chk("prog_voltage", prog_voltage, 16'h1234);
    i_smtc_host_model.cal_run();
    chk("low_point", i_smtc_host_model.m_lo, CAL_LOW_CODE);
    chk("high_point", i_smtc_host_model.m_hi, CAL_HIGH_CODE);
    chk("cal_slope", cal_slope, CAL_HIGH_CODE - CAL_LOW_CODE);
    chk("cal_offset", cal_offset, CAL_LOW_CODE);
    chk("cal_drive", cal_drive, 1'b0);
    stop_test();
  end
endmodule
